// File: rtl/uies_core.sv
// Interrupt enable, priority and status logic for one UART channel,
// with the enhanced register bank and the shared ready summary byte.
// Assumes FIFO, line control and modem logic live outside and feed
// their state in; one copy of this block per channel.
//
// How it works
// RULE1: Four basic sources gated by enables, reset 0
// RULE2: FIFO receive interrupt follows trigger level
// RULE3: Data ready sets on load, clears empty
// RULE4: FIFO on, enables off means polled mode
// RULE5: Line bits report overrun, head errors, global
// RULE6: Bit5 holding empty, bit6 all empty
// RULE7: Receive interrupt: held char or trigger
// RULE8: Transmit ready on empty; enabling fires immediately
// RULE9: Line interrupt from bits one to four
// RULE10: Modem interrupt from four delta flags
// RULE11: Sleep and upper enables need extended bit
// RULE12: Enable five gates Xoff/special match
// RULE13: Enable six: RTS rise under auto RTS
// RULE14: Enable seven: CTS rise under auto CTS
// RULE15: Extended fields locked unless extended bit set
// RULE16: Report highest; hold until serviced
// RULE17: Timeout after four chars plus twelve bits
// RULE18: Transmit ready on trigger cross or empty
// RULE19: Fixed six-bit codes in priority order
// RULE20: Each source clears by its own access
// RULE21: Enhanced bank only with key in line control
// RULE22: Summary byte when select pin low
// RULE23: Interrupt output high while anything pending
`timescale 1ns/1ps
`default_nettype none
`include "uies_params.svh"
module uies_core #(
   parameter int CHAR_BITS = `UIES_CHAR_BITS
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Host register bus
   input wire logic chip_select_i,
   input wire logic rd_strobe_i,
   input wire logic wr_strobe_i,
   input wire logic [2:0] addr_i,
   input wire logic [7:0] wr_data_i,
   input wire logic summary_select_n_i,
   output logic [7:0] rd_data_o,
   // Configuration held elsewhere
   input wire logic [7:0] line_control_i,
   input wire logic fifo_enable_i,
   input wire logic [6:0] rx_trigger_level_i,
   // Receiver state
   input wire logic [6:0] rx_fifo_count_i,
   input wire logic rx_char_load_i,
   input wire logic overrun_event_i,
   input wire logic head_new_i,
   input wire logic [2:0] head_err_i,
   input wire logic fifo_any_err_i,
   input wire logic bit_tick_i,
   input wire logic xoff_match_i,
   // Transmitter state
   input wire logic tx_holding_empty_i,
   input wire logic tx_all_empty_i,
   input wire logic tx_below_trigger_i,
   // Modem state
   input wire logic [3:0] modem_delta_i,
   input wire logic rts_n_i,
   input wire logic cts_n_i,
   // Ready lines of all four channels, index 3 is channel D
   input wire logic [3:0] receive_ready_event_n_i,
   input wire logic [3:0] transmit_ready_event_n_i,
   // Results
   output logic irq_o,
   output logic sleep_enable_o,
   output logic polled_mode_o,
   output logic [7:0] efc_o,
   output logic [7:0] xon_char_first_o,
   output logic [7:0] xon_char_second_o,
   output logic [7:0] xoff_char_first_o,
   output logic [7:0] xoff_char_second_o
);
   logic [7:0] ier_r, ier_nxt, efr_r, efr_nxt, rd_r, rd_nxt;
   logic [7:0] xchar_r [4];
   logic [7:0] xchar_nxt [4];
   logic [3:0] lerr_r, lerr_nxt;
   logic dr_r, dr_nxt, txp_r, txp_nxt, top_r, top_nxt;
   logic xop_r, xop_nxt, flp_r, flp_nxt;
   logic rts_q_r, cts_q_r, txsrc_q_r;
   uies_pkg::uies_src_e src_r, src_nxt;
   logic rd, wr, std_bank, enh_bank, ext;
   logic hold_rd, stat_rd, line_rd, modem_rd, hold_wr, mask_wr, efc_wr;
   logic rx_lvl, tx_src, to_exp;
   logic [6:0] pend;
   logic [7:0] line_status;
   logic [5:0] code;

   assign rd = chip_select_i && rd_strobe_i && summary_select_n_i;
   assign wr = chip_select_i && wr_strobe_i;
   assign std_bank = !line_control_i[`UIES_LCR_BANK];
   assign enh_bank = line_control_i == `UIES_LCR_KEY; // see RULE21
   assign ext = efr_r[`UIES_EFC_EXT];
   assign hold_rd = rd && std_bank && addr_i == `UIES_A_HOLD;
   assign stat_rd = rd && std_bank && addr_i == `UIES_A_STAT;
   assign line_rd = rd && std_bank && addr_i == `UIES_A_LINE;
   assign modem_rd = rd && std_bank && addr_i == `UIES_A_MODEM;
   assign hold_wr = wr && std_bank && addr_i == `UIES_A_HOLD;
   assign mask_wr = wr && std_bank && addr_i == `UIES_A_MASK;
   assign efc_wr = wr && enh_bank && addr_i == `UIES_A_EFC;

   // Data held: trigger level in FIFO mode, any character otherwise
   assign rx_lvl = fifo_enable_i ? (rx_fifo_count_i >= rx_trigger_level_i) // see RULE2
                                 : (rx_fifo_count_i != 7'h00); // see RULE7
   // Transmit source: trigger crossing or empty FIFO, else holding empty
   assign tx_src = fifo_enable_i ? (tx_below_trigger_i || tx_all_empty_i) // see RULE18
                                 : tx_holding_empty_i; // see RULE8

   // Polled bits stay valid with every enable off
   assign line_status = {fifo_any_err_i, tx_all_empty_i, tx_holding_empty_i, // see RULE6
                         lerr_r, dr_r}; // see RULE5
   assign polled_mode_o = fifo_enable_i && ier_r[3:0] == 4'h0; // see RULE4

   uies_rx_timeout #(
      .CHAR_BITS(CHAR_BITS)
   ) u_timeout (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .waiting_i(rx_fifo_count_i != 7'h00),
      .kick_i(hold_rd || rx_char_load_i),
      .bit_tick_i(bit_tick_i),
      .expire_o(to_exp)
   );

   // Upper sources also need the extended bit, so clearing it hides them
   always_comb begin
      pend[0] = ier_r[2] && lerr_r != 4'h0; // see RULE9
      pend[1] = ier_r[0] && top_r; // see RULE17
      pend[2] = ier_r[0] && rx_lvl; // see RULE1
      pend[3] = ier_r[1] && txp_r;
      pend[4] = ier_r[3] && modem_delta_i != 4'h0; // see RULE10
      pend[5] = ext && ier_r[5] && xop_r; // see RULE12
      pend[6] = ext && flp_r; // see RULE15
   end

   uies_prio u_prio (
      .pend_i(pend),
      .held_i(src_r),
      .src_o(src_nxt),
      .code_o(code)
   );

   assign irq_o = pend != 7'h00; // see RULE23

   always_comb begin
      ier_nxt = ier_r;
      efr_nxt = efr_r;
      xchar_nxt = xchar_r;
      rd_nxt = rd_r;
      if (mask_wr) begin
         ier_nxt[3:0] = wr_data_i[3:0];
         if (ext) begin
            ier_nxt[7:4] = wr_data_i[7:4]; // see RULE11
         end
      end
      if (efc_wr) begin
         efr_nxt = wr_data_i;
      end
      for (int i = 0; i < 4; i++) begin
         if (wr && enh_bank && addr_i == 3'(`UIES_A_XON_CHAR_FIRST + i)) begin
            xchar_nxt[i] = wr_data_i; // see RULE21
         end
      end
      if (chip_select_i && rd_strobe_i) begin
         rd_nxt = 8'h00;
         if (!summary_select_n_i) begin
            rd_nxt = {receive_ready_event_n_i, transmit_ready_event_n_i}; // see RULE22
         end else if (enh_bank) begin
            if (addr_i == `UIES_A_EFC) begin
               rd_nxt = efr_r;
            end else if (addr_i[2]) begin
               rd_nxt = xchar_r[addr_i[1:0]];
            end
         end else if (std_bank) begin
            unique case (addr_i)
               `UIES_A_MASK: rd_nxt = ext ? ier_r : {4'h0, ier_r[3:0]}; // see RULE15
               `UIES_A_STAT: rd_nxt = {fifo_enable_i, fifo_enable_i, code}; // see RULE16
               `UIES_A_LINE: rd_nxt = line_status;
               default: rd_nxt = 8'h00;
            endcase
         end
      end
   end

   // Sticky flags: in every one of them a set in the clearing cycle wins
   always_comb begin
      dr_nxt = dr_r;
      lerr_nxt = lerr_r;
      txp_nxt = txp_r;
      top_nxt = top_r;
      xop_nxt = xop_r;
      flp_nxt = flp_r;
      if (rx_fifo_count_i == 7'h00) begin
         dr_nxt = 1'b0;
      end
      if (rx_char_load_i) begin
         dr_nxt = 1'b1; // see RULE3
      end
      if (line_rd) begin
         lerr_nxt = 4'h0;
      end
      if (overrun_event_i) begin
         lerr_nxt[0] = 1'b1; // see RULE9
      end
      if (head_new_i) begin
         lerr_nxt[3:1] = lerr_nxt[3:1] | head_err_i;
      end
      if (stat_rd || hold_wr) begin
         txp_nxt = 1'b0; // see RULE20
      end
      if ((tx_src && !txsrc_q_r) || (mask_wr && wr_data_i[1] && !ier_r[1] && tx_src)) begin
         txp_nxt = 1'b1; // see RULE8
      end
      if (hold_rd) begin
         top_nxt = 1'b0;
      end
      if (to_exp) begin
         top_nxt = 1'b1;
      end
      if (stat_rd) begin
         xop_nxt = 1'b0;
      end
      if (xoff_match_i) begin
         xop_nxt = 1'b1;
      end
      if (modem_rd) begin
         flp_nxt = 1'b0;
      end
      if (ier_r[6] && efr_r[`UIES_EFC_ARTS] && rts_n_i && !rts_q_r) begin
         flp_nxt = 1'b1; // see RULE13
      end
      if (ier_r[7] && efr_r[`UIES_EFC_ACTS] && cts_n_i && !cts_q_r) begin
         flp_nxt = 1'b1; // see RULE14
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ier_r <= `UIES_MASK_RST; // see RULE1
         efr_r <= `UIES_EFC_RST;
         xchar_r <= '{default: `UIES_CHAR_RST};
         rd_r <= 8'h00;
         lerr_r <= 4'h0;
         dr_r <= 1'b0;
         txp_r <= 1'b0;
         top_r <= 1'b0;
         xop_r <= 1'b0;
         flp_r <= 1'b0;
         rts_q_r <= 1'b1; // Idle high: no false rising edge after reset
         cts_q_r <= 1'b1;
         txsrc_q_r <= 1'b1; // A stale edge here would give a late spurious tx ready
         src_r <= uies_pkg::SRC_NONE;
      end else begin
         ier_r <= ier_nxt;
         efr_r <= efr_nxt;
         xchar_r <= xchar_nxt;
         rd_r <= rd_nxt;
         lerr_r <= lerr_nxt;
         dr_r <= dr_nxt;
         txp_r <= txp_nxt;
         top_r <= top_nxt;
         xop_r <= xop_nxt;
         flp_r <= flp_nxt;
         rts_q_r <= rts_n_i;
         cts_q_r <= cts_n_i;
         txsrc_q_r <= tx_src;
         src_r <= src_nxt;
      end
   end

   assign rd_data_o = rd_r;
   assign sleep_enable_o = ier_r[4]; // see RULE11
   assign efc_o = efr_r;
   assign xon_char_first_o = xchar_r[0];
   assign xon_char_second_o = xchar_r[1];
   assign xoff_char_first_o = xchar_r[2];
   assign xoff_char_second_o = xchar_r[3];

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   property p_rxd_trigger;
      ier_r[0] && fifo_enable_i && rx_fifo_count_i >= rx_trigger_level_i |-> irq_o;
   endproperty
   a_rxd_trigger: assert property (p_rxd_trigger) else $error("receive trigger without irq"); // see RULE2

   property p_data_ready;
      rx_char_load_i |=> dr_r ##1 (dr_r || $past(rx_fifo_count_i) == 7'h00);
   endproperty
   a_data_ready: assert property (p_data_ready) else $error("data ready not set on load"); // see RULE3

   property p_all_off;
      ier_r == 8'h00 |-> !irq_o && code == `UIES_C_NONE;
   endproperty
   a_all_off: assert property (p_all_off) else $error("irq with all enables off"); // see RULE1

   property p_ext_lock;
      mask_wr && !ext |=> ier_r[7:4] == $past(ier_r[7:4]);
   endproperty
   a_ext_lock: assert property (p_ext_lock) else $error("upper enables written while locked"); // see RULE11

   property p_tx_enable;
      mask_wr && wr_data_i[1] && !ier_r[1] && tx_src && !stat_rd && !hold_wr |=> irq_o;
   endproperty
   a_tx_enable: assert property (p_tx_enable) else $error("enabling tx ready gave no irq"); // see RULE8

   property p_overrun;
      overrun_event_i && ier_r[2] && !mask_wr |=> irq_o ##0 src_nxt == uies_pkg::SRC_LINE
         || src_r != uies_pkg::SRC_NONE;
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun did not raise irq"); // see RULE9

   property p_none_code;
      !irq_o |-> code == `UIES_C_NONE;
   endproperty
   a_none_code: assert property (p_none_code) else $error("code not none while idle"); // see RULE19

   property p_xoff_clear;
      stat_rd && !xoff_match_i |=> !xop_r;
   endproperty
   a_xoff_clear: assert property (p_xoff_clear) else $error("xoff flag survived status read"); // see RULE20

   property p_key;
      wr && addr_i == `UIES_A_EFC && line_control_i != `UIES_LCR_KEY |=> $stable(efr_r);
   endproperty
   a_key: assert property (p_key) else $error("enhanced register written without key"); // see RULE21

   property p_hold;
      src_r != uies_pkg::SRC_NONE && (pend & src_r) != 7'h00 |-> src_nxt == src_r;
   endproperty
   a_hold: assert property (p_hold) else $error("reported source replaced early"); // see RULE16

   c_timeout: cover property (to_exp ##1 irq_o);
   c_flow: cover property (flp_r && irq_o);
   c_summary: cover property (chip_select_i && rd_strobe_i && !summary_select_n_i);
endmodule
`default_nettype wire

// File: include/uies_params.svh
// Constants for the per-channel interrupt enable and status block.
// Included by the bench and by every design file that needs a number.
`ifndef UIES_PARAMS_SVH
`define UIES_PARAMS_SVH

// Standard bank, reached while line control bit 7 is 0
`define UIES_A_HOLD 3'h0
`define UIES_A_MASK 3'h1
`define UIES_A_STAT 3'h2
`define UIES_A_LINE 3'h5
`define UIES_A_MODEM 3'h6
// Enhanced bank, reached while line control holds the key value
`define UIES_A_EFC 3'h2
`define UIES_A_XON_CHAR_FIRST 3'h4
`define UIES_A_XON_CHAR_SECOND 3'h5
`define UIES_A_XOFF_CHAR_FIRST 3'h6
`define UIES_A_XOFF_CHAR_SECOND 3'h7
`define UIES_LCR_KEY 8'hBF
`define UIES_LCR_BANK 7

// Field positions of the enhanced feature control register
`define UIES_EFC_EXT 4
`define UIES_EFC_ARTS 6
`define UIES_EFC_ACTS 7

// Reset values
`define UIES_MASK_RST 8'h00
`define UIES_EFC_RST 8'h00
`define UIES_CHAR_RST 8'h00

// Status codes, bits 5:0
`define UIES_C_LINE 6'h06
`define UIES_C_TOUT 6'h0C
`define UIES_C_RXD 6'h04
`define UIES_C_TXR 6'h02
`define UIES_C_MODEM 6'h00
`define UIES_C_XOFF 6'h10
`define UIES_C_FLOW 6'h20
`define UIES_C_NONE 6'h01

// Receive timeout: four character times plus twelve bit times
`define UIES_TO_CHARS 4
`define UIES_TO_BITS 12
`define UIES_CHAR_BITS 10

`endif

// File: include/uies_pkg.sv
// Types shared by the interrupt enable and status block.
// Assumes uies_params.svh is on the include path.
package uies_pkg;
   // One-hot interrupt sources, bit order is priority order
   typedef enum logic [6:0] {
      SRC_NONE = 7'h00,
      SRC_LINE = 7'h01,
      SRC_TOUT = 7'h02,
      SRC_RXD = 7'h04,
      SRC_TXR = 7'h08,
      SRC_MODEM = 7'h10,
      SRC_XOFF = 7'h20,
      SRC_FLOW = 7'h40
   } uies_src_e;
endpackage

// File: rtl/uies_rx_timeout.sv
// Receive timeout timer for one channel.
// Assumes bit_tick_i pulses once per bit time on the block clock.
`timescale 1ns/1ps
`default_nettype none
`include "uies_params.svh"
module uies_rx_timeout #(
   parameter int CHAR_BITS = `UIES_CHAR_BITS
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Control
   input wire logic waiting_i,
   input wire logic kick_i,
   input wire logic bit_tick_i,
   // Result
   output logic expire_o
);
   localparam int LIMIT = `UIES_TO_CHARS * CHAR_BITS + `UIES_TO_BITS;
   localparam logic [7:0] LIMIT_C = 8'(LIMIT);
   logic [7:0] cnt_r, cnt_nxt;
   logic expire_nxt;

   // Counts only while data waits; a read or a new character restarts it
   always_comb begin
      cnt_nxt = cnt_r;
      expire_nxt = 1'b0;
      if (kick_i || !waiting_i) begin
         cnt_nxt = 8'h00;
      end else if (bit_tick_i && cnt_r != LIMIT_C) begin
         cnt_nxt = cnt_r + 8'h01;
         expire_nxt = (cnt_r + 8'h01) == LIMIT_C; // see RULE17
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_r <= 8'h00;
         expire_o <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         expire_o <= expire_nxt;
      end
   end
endmodule
`default_nettype wire

// File: rtl/uies_prio.sv
// Priority selection of the reported interrupt source.
// Purely combinational; the caller registers the held source.
`timescale 1ns/1ps
`default_nettype none
`include "uies_params.svh"
module uies_prio (
   // Pending sources and the one now reported
   input wire logic [6:0] pend_i,
   input wire uies_pkg::uies_src_e held_i,
   // Selection
   output uies_pkg::uies_src_e src_o,
   output logic [5:0] code_o
);
   // A reported source stays until serviced, so a later one waits
   always_comb begin
      src_o = uies_pkg::SRC_NONE;
      if ((pend_i & held_i) != 7'h00) begin
         src_o = held_i; // see RULE16
      end else begin
         for (int i = 6; i >= 0; i--) begin
            if (pend_i[i]) begin
               src_o = uies_pkg::uies_src_e'(7'h01 << i);
            end
         end
      end
   end

   always_comb begin
      unique case (src_o)
         uies_pkg::SRC_LINE: code_o = `UIES_C_LINE; // see RULE19
         uies_pkg::SRC_TOUT: code_o = `UIES_C_TOUT;
         uies_pkg::SRC_RXD: code_o = `UIES_C_RXD;
         uies_pkg::SRC_TXR: code_o = `UIES_C_TXR;
         uies_pkg::SRC_MODEM: code_o = `UIES_C_MODEM;
         uies_pkg::SRC_XOFF: code_o = `UIES_C_XOFF;
         uies_pkg::SRC_FLOW: code_o = `UIES_C_FLOW;
         default: code_o = `UIES_C_NONE;
      endcase
   end
endmodule
`default_nettype wire

// File: verification/uies_host_model.sv
// Host processor model that drives the register bus of one channel.
// Assumes the bench calls access and samples read data while seen_o is high.
`timescale 1ns/1ps
`default_nettype none
module uies_host_model (
   // Clock
   input wire logic clk_i,
   // Register bus
   output logic chip_select_o,
   output logic rd_strobe_o,
   output logic wr_strobe_o,
   output logic [2:0] addr_o,
   output logic [7:0] wr_data_o,
   output logic summary_select_n_o,
   // Read finished, data valid for one cycle
   output logic seen_o
);
   initial begin
      chip_select_o = 1'b0;
      rd_strobe_o = 1'b0;
      wr_strobe_o = 1'b0;
      addr_o = 3'h0;
      wr_data_o = 8'h00;
      summary_select_n_o = 1'b1;
      seen_o = 1'b0;
   end

   // Strobes last one cycle: a longer read would repeat its clearing side effects
   task automatic access(input logic w, input logic [2:0] a, input logic [7:0] d,
                         input logic sel_n, input logic k);
      @(posedge clk_i);
      #2;
      chip_select_o = 1'b1;
      rd_strobe_o = ~w;
      wr_strobe_o = w;
      addr_o = a;
      wr_data_o = d;
      summary_select_n_o = sel_n;
      @(posedge clk_i);
      #2;
      chip_select_o = 1'b0;
      rd_strobe_o = 1'b0;
      wr_strobe_o = 1'b0;
      // Released lines must not keep the last value
      addr_o = ~a;
      wr_data_o = ~d;
      summary_select_n_o = 1'b1;
      if (k) begin
         seen_o = 1'b1;
         @(posedge clk_i);
         #2;
         seen_o = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// File: verification/uies_core_tb.sv
// Self-checking bench for the channel interrupt enable and status block.
// Assumes the host model owns the bus; the bench drives all other state.
`timescale 1ns/1ps
`default_nettype none
`include "uies_params.svh"
module uies_core_tb;
   logic clk, resetn, cs, rd, wr, ssn, seen, fen, load, ovr, hnew, aerr, tick, xm;
   logic the, tae, tbt, rts_n, cts_n, irq, sleep, polled;
   logic [2:0] addr, herr;
   logic [3:0] md, rxr_n, txr_n;
   logic [6:0] trig, cnt;
   logic [7:0] wd, rdd, line_control, efc, x1, x2, f1, f2, v;
   logic [7:0] ch[4:7];
   logic [7:0] expq[$];
   logic [31:0] seed = 32'h15;
   int n_fail = 0;
   int checked = 0;

   // Short character time keeps the timeout wait small
   uies_core #(.CHAR_BITS(2)) uies_core_inst (.clk_i(clk), .resetn_i(resetn),
      .chip_select_i(cs), .rd_strobe_i(rd), .wr_strobe_i(wr), .addr_i(addr),
      .wr_data_i(wd), .summary_select_n_i(ssn), .rd_data_o(rdd), .line_control_i(line_control),
      .fifo_enable_i(fen), .rx_trigger_level_i(trig), .rx_fifo_count_i(cnt),
      .rx_char_load_i(load), .overrun_event_i(ovr), .head_new_i(hnew),
      .head_err_i(herr), .fifo_any_err_i(aerr), .bit_tick_i(tick), .xoff_match_i(xm),
      .tx_holding_empty_i(the), .tx_all_empty_i(tae), .tx_below_trigger_i(tbt),
      .modem_delta_i(md), .rts_n_i(rts_n), .cts_n_i(cts_n),
      .receive_ready_event_n_i(rxr_n), .transmit_ready_event_n_i(txr_n), .irq_o(irq),
      .sleep_enable_o(sleep), .polled_mode_o(polled), .efc_o(efc), .xon_char_first_o(x1),
      .xon_char_second_o(x2), .xoff_char_first_o(f1), .xoff_char_second_o(f2));

   uies_host_model uies_host_model_inst (.clk_i(clk), .chip_select_o(cs),
      .rd_strobe_o(rd), .wr_strobe_o(wr), .addr_o(addr), .wr_data_o(wd),
      .summary_select_n_o(ssn), .seen_o(seen));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic complete_run();
      if (expq.size() != 0) begin
         n_fail++;
      end
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      checked++;
      if (s !== e) begin
         n_fail++;
         $display("BAD t=%0t seen %h expected %h", $time, s, e);
      end
   endtask

   task automatic flag(input logic s, input logic e);
      chk({7'h00, s}, {7'h00, e});
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask

   task automatic pulse(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
      cyc(1);
   endtask

   task automatic rise(ref logic s);
      s = 1'b0;
      cyc(2);
      s = 1'b1;
      cyc(2);
   endtask

   task automatic wreg(input logic [2:0] a, input logic [7:0] d);
      uies_host_model_inst.access(1'b1, a, d, 1'b1, 1'b0);
   endtask

   task automatic rreg(input logic [2:0] a, input logic [7:0] e);
      expq.push_back(e);
      uies_host_model_inst.access(1'b0, a, 8'h00, 1'b1, 1'b1);
   endtask

   // Read for its clearing effect only; the data belongs to other logic
   task automatic rskip(input logic [2:0] a);
      uies_host_model_inst.access(1'b0, a, 8'h00, 1'b1, 1'b0);
   endtask

   function automatic logic [7:0] st(input logic [5:0] c);
      return {fen, fen, c};
   endfunction

   always @(negedge clk) begin
      if (seen === 1'b1 && expq.size() > 0) begin
         chk(rdd, expq.pop_front());
      end
   end

   initial begin
      repeat (4000) @(posedge clk);
      n_fail++;
      complete_run();
   end

   initial begin
      {resetn, fen, load, ovr, hnew, aerr, tick, xm, tbt} = 9'h000;
      {the, tae, rts_n, cts_n} = 4'hF;
      {herr, md, rxr_n, txr_n} = 15'h00FF;
      line_control = 8'h03;
      trig = 7'h04;
      cnt = 7'h00;
      cyc(3);
      resetn = 1'b1;
      rreg(3'h1, 8'h00);
      rreg(3'h2, st(`UIES_C_NONE));
      flag(polled, 1'b0);
      fen = 1'b1;
      cyc(1);
      flag(polled, 1'b1);
      wreg(3'h1, 8'hFF);
      rreg(3'h1, 8'h0F);
      flag(irq, 1'b1);
      rreg(3'h2, st(`UIES_C_TXR));
      flag(irq, 1'b0);
      rreg(3'h2, st(`UIES_C_NONE));
      line_control = `UIES_LCR_KEY;
      wreg(`UIES_A_EFC, 8'hD0);
      rreg(`UIES_A_EFC, 8'hD0);
      for (int i = 4; i < 8; i++) begin
         v = 8'(rnd());
         ch[i] = v;
         wreg(3'(i), v);
         rreg(3'(i), v);
      end
      chk(efc, 8'hD0);
      chk(x2, ch[5]);
      chk(f1, ch[6]);
      chk(f2, ch[7]);
      line_control = 8'h03;
      wreg(3'h4, ~ch[4]);
      chk(x1, ch[4]);
      wreg(3'h1, 8'h10);
      rreg(3'h1, 8'h10);
      flag(sleep, 1'b1);
      wreg(3'h1, 8'hE0);
      pulse(xm);
      flag(irq, 1'b1);
      rreg(3'h2, st(`UIES_C_XOFF));
      rreg(3'h2, st(`UIES_C_NONE));
      rise(cts_n);
      rreg(3'h2, st(`UIES_C_FLOW));
      rskip(3'h6);
      rreg(3'h2, st(`UIES_C_NONE));
      rise(rts_n);
      rreg(3'h2, st(`UIES_C_FLOW));
      rskip(3'h6);
      wreg(3'h1, 8'h20);
      rise(cts_n);
      rreg(3'h2, st(`UIES_C_NONE));
      rskip(3'h6);
      wreg(3'h1, 8'h05);
      pulse(ovr);
      flag(irq, 1'b1);
      cnt = 7'h04;
      pulse(load);
      rreg(3'h2, st(`UIES_C_LINE));
      rreg(3'h5, 8'h63);
      rreg(3'h5, 8'h61);
      rreg(3'h2, st(`UIES_C_RXD));
      cnt = 7'h03;
      cyc(1);
      flag(irq, 1'b0);
      herr = 3'h7;
      pulse(hnew);
      herr = 3'h0;
      rreg(3'h2, st(`UIES_C_LINE));
      rreg(3'h5, 8'h7D);
      aerr = 1'b1;
      tae = 1'b0;
      rreg(3'h5, 8'hA1);
      cnt = 7'h00;
      cyc(1);
      rreg(3'h5, 8'hA0);
      aerr = 1'b0;
      tae = 1'b1;
      wreg(3'h1, 8'h08);
      for (int i = 0; i < 4; i++) begin
         md = 4'h1 << i;
         cyc(1);
         rreg(3'h2, st(`UIES_C_MODEM));
         md = 4'h0;
         cyc(1);
         flag(irq, 1'b0);
      end
      wreg(3'h1, 8'h01);
      trig = 7'h08;
      cnt = 7'h01;
      tick = 1'b1;
      pulse(load);
      cyc(14);
      flag(irq, 1'b0);
      cyc(10);
      flag(irq, 1'b1);
      tick = 1'b0;
      rreg(3'h2, st(`UIES_C_TOUT));
      rskip(3'h0);
      rreg(3'h2, st(`UIES_C_NONE));
      cnt = 7'h00;
      for (int i = 0; i < 3; i++) begin
         v = 8'(rnd());
         rxr_n = v[7:4];
         txr_n = v[3:0];
         expq.push_back(v);
         uies_host_model_inst.access(1'b0, v[2:0], 8'h00, 1'b0, 1'b1);
      end
      wreg(3'h1, 8'h02);
      rreg(3'h2, st(`UIES_C_TXR));
      the = 1'b0;
      tae = 1'b0;
      cyc(1);
      tbt = 1'b1;
      cyc(1);
      flag(irq, 1'b1);
      wreg(3'h0, 8'h55);
      flag(irq, 1'b0);
      fen = 1'b0;
      cnt = 7'h01;
      wreg(3'h1, 8'h01);
      rreg(3'h2, st(`UIES_C_RXD));
      cnt = 7'h00;
      wreg(3'h1, 8'h02);
      flag(irq, 1'b0);
      the = 1'b1;
      cyc(1);
      flag(irq, 1'b1);
      rreg(3'h2, st(`UIES_C_TXR));
      complete_run();
   end
endmodule
`default_nettype wire
